// ---- hdl/fsrb_spi_rx.sv ----
// Oversampled serial frame receiver with in-frame response
`timescale 1ns/1ps
module fsrb_spi_rx (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  fsrb_frame_if.rx frame
);
  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  logic [2:0] pin_w;
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] last_q;
  assign pin_w = {sclk, cs_n, mosi};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[gi] <= gi == 1;
          sync_q[gi] <= gi == 1;
          last_q[gi] <= gi == 1;
        end else if (ce) begin
          meta_q[gi] <= pin_w[gi];
          sync_q[gi] <= meta_q[gi];
          last_q[gi] <= sync_q[gi];
        end
      end
    end
  endgenerate
  wire sclk_rise = sync_q[2] & ~last_q[2];
  wire sclk_fall = ~sync_q[2] & last_q[2];
  wire cs_fall = ~sync_q[1] & last_q[1];
  wire cs_rise = sync_q[1] & ~last_q[1];
  wire mosi_s = sync_q[0];
  // --------------------------------------------------------------
  // Bit counting
  // --------------------------------------------------------------
  fsrb_pkg::fsrb_rx_state_type state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [7:0] shin_q, tx_q, addr_q;
  logic valid_q, done_q, err_q, miso_q;
  wire active = state_q != fsrb_pkg::RX_IDLE;
  wire addr_end = sclk_rise && state_q == fsrb_pkg::RX_ADDR &&
                  cnt_q == fsrb_pkg::ADDR_LAST_BIT_C;
  wire full_frame = cnt_q == fsrb_pkg::FRAME_BITS_C;
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (cs_fall) begin
      state_d = fsrb_pkg::RX_ADDR;
      cnt_d = 5'h00;
    end else if (cs_rise) begin
      state_d = fsrb_pkg::RX_IDLE;
    end else if (sclk_rise && active) begin
      if (cnt_q != fsrb_pkg::COUNT_MAX_C) begin
        cnt_d = cnt_q + 5'h01;
      end
      case (state_q)
        fsrb_pkg::RX_ADDR: if (addr_end) state_d = fsrb_pkg::RX_DATA;
        fsrb_pkg::RX_DATA: begin
          if (cnt_q == fsrb_pkg::FRAME_BITS_C - 5'h01) begin
            state_d = fsrb_pkg::RX_OVER;
          end
        end
        fsrb_pkg::RX_OVER: state_d = fsrb_pkg::RX_OVER;
        default: state_d = fsrb_pkg::RX_IDLE;
      endcase
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= fsrb_pkg::RX_IDLE;
      cnt_q <= 5'h00;
      shin_q <= 8'h00;
      addr_q <= 8'h00;
      valid_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (sclk_rise && active) shin_q <= {shin_q[6:0], mosi_s};
      if (addr_end) addr_q <= {shin_q[6:0], mosi_s};
      valid_q <= addr_end;
      done_q <= cs_rise && active && full_frame;
      err_q <= cs_rise && active && !full_frame;
    end
  end
  // --------------------------------------------------------------
  // Response shifter, bank answer loaded once the address is in
  // --------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= 8'h00;
      miso_q <= 1'b0;
    end else if (ce) begin
      if (cs_fall) begin
        tx_q <= 8'h00;
        miso_q <= 1'b0;
      end else if (valid_q) begin
        tx_q <= frame.resp_byte;
      end else if (sclk_fall && active) begin
        miso_q <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end
  assign miso = miso_q;
  assign miso_oe_n = !active;
  assign frame.addr_byte = addr_q;
  assign frame.addr_valid = valid_q;
  assign frame.frame_done = done_q;
  assign frame.frame_error = err_q;
endmodule

// ---- hdl/fsrb_top.sv ----
// Read-and-clear fault status bank behind a 16-bit serial frame
// Operation
// - All status registers reset to zero
// - Frame is address byte then data byte
// - Address bit seven low reads only
// - Address bit seven high clears latched bits, bit three reads one
// - Latched bits never clear without host command
// - Protocol error latches global bit seven
// - Bit six is OR of load errors
// - Load error drops when sources clear
// - Undervoltage latches bit five, outputs off
// - Overvoltage latches bit four, outputs off
// - Bit three zero after power-on reset
// - Thermal shutdown latches bit two, outputs off
// - Prewarning sets bit one, outputs stay
// - Bit zero always reads zero
// - Overcurrent map: bridge four high first
// - Overcurrent latches bit, switch off
// - Global register address field 00110
// - Overcurrent register address field 10110
`timescale 1ns/1ps
module fsrb_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  input wire logic uv_detect,
  input wire logic ov_detect,
  input wire logic shutdown_detect,
  input wire logic prewarn_detect,
  input wire logic open_load_any,
  input wire logic [7:0] oc_detect,
  output logic all_outputs_off,
  output logic [7:0] switch_off
);
  // --------------------------------------------------------------
  // Serial frame receiver
  // --------------------------------------------------------------
  fsrb_frame_if frame_if ();
  fsrb_spi_rx u_rx (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .miso(miso),
    .miso_oe_n(miso_oe_n),
    .frame(frame_if.rx)
  );
  // --------------------------------------------------------------
  // Fault detector synchronisers
  // --------------------------------------------------------------
  // Detectors are analog comparators with no relation to clock
  localparam int NRAW = 13;
  logic [NRAW-1:0] raw_w;
  logic [NRAW-1:0] meta_q;
  logic [NRAW-1:0] sync_q;
  assign raw_w = {uv_detect, ov_detect, shutdown_detect, prewarn_detect,
                  open_load_any, oc_detect};
  genvar gi;
  generate
    for (gi = 0; gi < NRAW; gi++) begin : g_sync
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else if (ce) begin
          meta_q[gi] <= raw_w[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate
  wire uv_s = sync_q[12];
  wire ov_s = sync_q[11];
  wire shutdown_s = sync_q[10];
  wire prewarn_s = sync_q[9];
  wire ol_s = sync_q[8];
  // bit seven bridge four high side
  wire [7:0] oc_s = sync_q[7:0];
  // --------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------
  wire [7:0] addr = frame_if.addr_byte;
  wire clear_sel = addr[fsrb_pkg::CLEAR_SEL_BIT];
  wire tail_ok = addr[fsrb_pkg::TAIL_BIT];
  wire [4:0] field = addr[fsrb_pkg::ADDR_MSB:fsrb_pkg::ADDR_LSB];
  wire hit_glob = tail_ok && field == fsrb_pkg::ADDR_GLOBAL_C;
  wire hit_oc = tail_ok && field == fsrb_pkg::ADDR_OC1_C;
  wire clr_glob = frame_if.frame_done && clear_sel && hit_glob;
  wire clr_oc = frame_if.frame_done && clear_sel && hit_oc;
  // --------------------------------------------------------------
  // Global status
  // --------------------------------------------------------------
  logic [7:0] gstat_q, gstat_d;
  logic [7:0] gset_w;
  logic [7:0] oc_q, oc_d;
  logic off_q;
  logic [7:0] sw_off_q;
  assign gset_w = {frame_if.frame_error, 1'b0, uv_s, ov_s, 1'b0,
                   shutdown_s, prewarn_s, 1'b0};
  always_comb begin
    // only a clear drops a bit, set wins
    gstat_d = ((gstat_q & ~{8{clr_glob}}) | gset_w)
              & fsrb_pkg::LATCH_MASK_C;
    // reads one once power-on was acknowledged
    gstat_d[fsrb_pkg::NO_POR_BIT] = gstat_q[fsrb_pkg::NO_POR_BIT]
                                  | clr_glob;
  end
  // latch per switch, set wins over clear
  assign oc_d = (oc_q & ~{8{clr_oc}}) | oc_s;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gstat_q <= fsrb_pkg::STATUS_RESET_C;
      oc_q <= fsrb_pkg::STATUS_RESET_C;
      off_q <= 1'b0;
      sw_off_q <= 8'h00;
    end else if (ce) begin
      gstat_q <= gstat_d;
      oc_q <= oc_d;
      off_q <= |(gstat_d & fsrb_pkg::OFF_MASK_C);
      sw_off_q <= oc_d | {8{|(gstat_d & fsrb_pkg::OFF_MASK_C)}};
    end
  end
  assign all_outputs_off = off_q;
  assign switch_off = sw_off_q;
  // --------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------
  // live OR, falls once sources clear
  wire load_err = (|oc_q) | ol_s;
  logic [7:0] glob_rd;
  always_comb begin
    glob_rd = gstat_q;
    glob_rd[fsrb_pkg::LOAD_ERR_BIT] = load_err;
    glob_rd[fsrb_pkg::RSVD_BIT] = 1'b0;
  end
  // read path has no side effect
  assign frame_if.resp_byte = hit_glob ? glob_rd :
                              hit_oc ? oc_q : 8'h00;
  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_reset_zero;
    $rose(rst_n) |-> gstat_q == 8'h00 && oc_q == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("status not zero after reset");

  property p_read_keeps;
    ce && frame_if.frame_done && !clear_sel |=>
      (oc_q & $past(oc_q)) == $past(oc_q);
  endproperty
  a_read_keeps: assert property (p_read_keeps)
    else $error("read command dropped a status bit");

  property p_clear_oc;
    ce && clr_oc && oc_s == 8'h00 |=> oc_q == 8'h00
      && glob_rd[fsrb_pkg::LOAD_ERR_BIT] == ol_s;
  endproperty
  a_clear_oc: assert property (p_clear_oc)
    else $error("clear command left overcurrent bits");

  property p_no_self_clear;
    ce && !clr_glob |=>
      (gstat_q & $past(gstat_q)) == $past(gstat_q);
  endproperty
  a_no_self_clear: assert property (p_no_self_clear)
    else $error("global bit fell without clear");

  property p_spi_err;
    ce && frame_if.frame_error |=> gstat_q[7] [*2];
  endproperty
  a_spi_err: assert property (p_spi_err)
    else $error("protocol error not latched");

  property p_load_err;
    hit_glob && oc_q != 8'h00 |-> frame_if.resp_byte[6];
  endproperty
  a_load_err: assert property (p_load_err)
    else $error("load error summary not set");

  property p_uv_off;
    ce && uv_s |=> gstat_q[5] && all_outputs_off
      && switch_off == 8'hFF;
  endproperty
  a_uv_off: assert property (p_uv_off)
    else $error("undervoltage did not disable outputs");

  property p_no_por;
    $rose(gstat_q[fsrb_pkg::NO_POR_BIT]) |-> $past(clr_glob);
  endproperty
  a_no_por: assert property (p_no_por)
    else $error("power-on flag rose without clear");

  property p_tpw_only;
    gstat_q[1] && gstat_q[5:4] == 2'b00 && !gstat_q[2]
      |-> !all_outputs_off;
  endproperty
  a_tpw_only: assert property (p_tpw_only)
    else $error("prewarning alone disabled outputs");

  property p_rsvd;
    hit_glob |-> !frame_if.resp_byte[0];
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit read as one");

  property p_oc_latch;
    ce && oc_s != 8'h00 |=>
      (oc_q & switch_off & $past(oc_s)) == $past(oc_s);
  endproperty
  a_oc_latch: assert property (p_oc_latch)
    else $error("overcurrent not latched or switch left on");

  property p_ov_off;
    ce && ov_s |=> gstat_q[fsrb_pkg::OV_BIT] && all_outputs_off
      && switch_off == 8'hFF;
  endproperty
  a_ov_off: assert property (p_ov_off)
    else $error("overvoltage did not disable outputs");

  property p_shutdown_off;
    ce && shutdown_s |=> gstat_q[fsrb_pkg::SHUTDOWN_BIT]
      && all_outputs_off && switch_off == 8'hFF;
  endproperty
  a_shutdown_off: assert property (p_shutdown_off)
    else $error("thermal shutdown did not disable outputs");

  property p_prewarn_set;
    ce && prewarn_s |=> gstat_q[fsrb_pkg::PREWARN_BIT];
  endproperty
  a_prewarn_set: assert property (p_prewarn_set)
    else $error("prewarning not latched");

  property p_load_drop;
    hit_glob && oc_q == 8'h00 && !ol_s
      |-> !frame_if.resp_byte[fsrb_pkg::LOAD_ERR_BIT];
  endproperty
  a_load_drop: assert property (p_load_drop)
    else $error("load error summary stuck high");

  property p_clear_glob;
    ce && clr_glob |=> (gstat_q & ~$past(gset_w))
      == (8'h01 << fsrb_pkg::NO_POR_BIT);
  endproperty
  a_clear_glob: assert property (p_clear_glob)
    else $error("clear command left global bits");

  property p_oc_persist;
    ce && clr_oc && oc_s != 8'h00 |=> oc_q == $past(oc_s);
  endproperty
  a_oc_persist: assert property (p_oc_persist)
    else $error("persisting overcurrent not set again");

  property p_freeze;
    !ce |=> $stable(gstat_q) && $stable(oc_q) && $stable(switch_off);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");

  property p_glob_read;
    hit_glob |-> (frame_if.resp_byte & fsrb_pkg::LATCH_MASK_C) == gstat_q;
  endproperty
  a_glob_read: assert property (p_glob_read)
    else $error("global register read wrong");

  property p_oc_read;
    hit_oc |-> frame_if.resp_byte == oc_q;
  endproperty
  a_oc_read: assert property (p_oc_read)
    else $error("overcurrent register read wrong");

  property p_unknown_zero;
    !hit_glob && !hit_oc |-> frame_if.resp_byte == 8'h00;
  endproperty
  a_unknown_zero: assert property (p_unknown_zero)
    else $error("unknown address answered nonzero");

  property p_clear_other;
    ce && frame_if.frame_done && !hit_oc |=>
      (oc_q & $past(oc_q)) == $past(oc_q);
  endproperty
  a_clear_other: assert property (p_clear_other)
    else $error("other command dropped an overcurrent bit");

  property p_addr_first;
    frame_if.addr_valid |-> !frame_if.frame_done && !frame_if.frame_error;
  endproperty
  a_addr_first: assert property (p_addr_first)
    else $error("address handed over at frame end");
endmodule

// ---- inc/fsrb_frame_if.sv ----
// Frame hand-off between the serial receiver and the register bank
`timescale 1ns/1ps
interface fsrb_frame_if;
  logic [7:0] addr_byte;
  logic addr_valid;
  logic frame_done;
  logic frame_error;
  logic [7:0] resp_byte;
  modport rx (
    output addr_byte, addr_valid, frame_done, frame_error,
    input resp_byte
  );
  modport bank (
    input addr_byte, addr_valid, frame_done, frame_error,
    output resp_byte
  );
endinterface

// ---- inc/fsrb_pkg.sv ----
// Constants and types of the fault status register bank
package fsrb_pkg;
  // --------------------------------------------------------------
  // Frame layout
  // --------------------------------------------------------------
  localparam logic [4:0] ADDR_LAST_BIT_C = 5'h07;
  localparam logic [4:0] FRAME_BITS_C = 5'h10;
  localparam logic [4:0] COUNT_MAX_C = 5'h1F;
  localparam int CLEAR_SEL_BIT = 7;
  localparam int ADDR_MSB = 6;
  localparam int ADDR_LSB = 2;
  localparam int TAIL_BIT = 0;
  localparam logic [4:0] ADDR_GLOBAL_C = 5'h06;
  localparam logic [4:0] ADDR_OC1_C = 5'h16;
  // --------------------------------------------------------------
  // Register contents
  // --------------------------------------------------------------
  localparam logic [7:0] STATUS_RESET_C = 8'h00;
  localparam logic [7:0] LATCH_MASK_C = 8'hBE;
  localparam logic [7:0] OFF_MASK_C = 8'h34;
  localparam int SPI_ERR_BIT = 7;
  localparam int LOAD_ERR_BIT = 6;
  localparam int UV_BIT = 5;
  localparam int OV_BIT = 4;
  localparam int NO_POR_BIT = 3;
  localparam int SHUTDOWN_BIT = 2;
  localparam int PREWARN_BIT = 1;
  localparam int RSVD_BIT = 0;
  localparam int OC_CHANNELS = 8;
  localparam int SYNC_STAGES = 2;
  // --------------------------------------------------------------
  // Frame receiver states
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_ADDR = 2'b01,
    RX_DATA = 2'b11,
    RX_OVER = 2'b10
  } fsrb_rx_state_type;
endpackage

// ---- verification/fsrb_host_model.sv ----
// Host side serial controller model driving frames of nbits clocks, 16 for a full frame
`timescale 1ns/1ps
module fsrb_host_model (
  input wire logic clock,
  input wire logic miso,
  input wire logic miso_oe_n,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  // ------------------------------------------------------------
  // Frame engine
  // ------------------------------------------------------------
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic frame(input logic [7:0] addr, input int nbits,
                       output logic [7:0] resp);
    logic [15:0] word;
    word = {addr, 8'h00};
    resp = 8'h00;
    wait_clk(1);
    cs_n = 1'b0;
    wait_clk(4);
    for (int i = 0; i < nbits; i++) begin
      mosi = (i < 16) ? word[15 - i] : 1'b0;
      wait_clk(4);
      sclk = 1'b1;
      wait_clk(2);
      // Undriven response bits must never pass as data
      if (i >= 8 && i < 16) begin
        resp = {resp[6:0], miso_oe_n ? 1'bx : miso};
      end
      wait_clk(2);
      sclk = 1'b0;
    end
    wait_clk(4);
    cs_n = 1'b1;
    // Released line shows the inverse, never a stale copy
    mosi = ~mosi;
    wait_clk(10);
  endtask
endmodule

// ---- verification/fsrb_top_tb.sv ----
// Self-checking bench of the fault status register bank
`timescale 1ns/1ps
module fsrb_top_tb;
  localparam logic [4:0] g_field = 5'h06;
  localparam logic [4:0] o_field = 5'h16;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] flt = 4'h0;
  logic ol = 1'b0;
  logic ce = 1'b1;
  logic [7:0] oc = 8'h00;
  logic sclk, cs_n, mosi, miso, miso_oe_n, aoff;
  logic [7:0] soff, r, gexp, ocexp, v;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 32'hed483dad;
  int bitpos [4] = '{5, 4, 2, 1};

  always #20 clock = ~clock;

  fsrb_top dut (.clock(clock), .rst_n(rst_n), .ce(ce), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
    .uv_detect(flt[3]), .ov_detect(flt[2]), .shutdown_detect(flt[1]),
    .prewarn_detect(flt[0]), .open_load_any(ol), .oc_detect(oc),
    .all_outputs_off(aoff), .switch_off(soff));
  fsrb_host_model host (.clock(clock), .miso(miso),
    .miso_oe_n(miso_oe_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));

  // ------------------------------------------------------------
  // Expectations and helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] glob(input logic [7:0] g,
                                      input logic [7:0] o, input logic l);
    return {g[7], (|o) | l, g[5:1], 1'b0};
  endfunction

  function automatic logic [7:0] abyte(input logic sel, input logic [4:0] f);
    return {sel, f, 1'b0, 1'b1};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic rd(input logic [4:0] f, output logic [7:0] d);
    host.frame(abyte(1'b0, f), 16, d);
  endtask

  task automatic clr(input logic [4:0] f);
    logic [7:0] d;
    host.frame(abyte(1'b1, f), 16, d);
  endtask

  task automatic do_reset;
    rst_n = 1'b0;
    wait_clk(8);
    rst_n = 1'b1;
    wait_clk(6);
    gexp = 8'h00;
    ocexp = 8'h00;
  endtask

  task automatic pulse_flt(input int k);
    flt[3 - k] = 1'b1;
    wait_clk(4);
    flt[3 - k] = 1'b0;
    wait_clk(4);
  endtask

  // Long frames: about 150 cycles each, some 65 of them
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors = errors + 1;
      report_and_stop;
    end
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    do_reset;
    rd(g_field, r);
    check(r, 8'h00);
    rd(o_field, r);
    check(r, 8'h00);
    check(soff, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      pulse_flt(k);
      gexp[bitpos[k]] = 1'b1;
      rd(g_field, r);
      check(r, glob(gexp, ocexp, 1'b0));
      check({7'h00, aoff}, {7'h00, k != 3});
      check(soff, {8{k != 3}});
      rd(g_field, r);
      check(r, glob(gexp, ocexp, 1'b0));
      clr(g_field);
      gexp = 8'h08;
      rd(g_field, r);
      check(r, glob(gexp, ocexp, 1'b0));
      check({7'h00, aoff}, 8'h00);
    end
    $display("test faults done");
    ol = 1'b1;
    wait_clk(4);
    rd(g_field, r);
    check(r, glob(gexp, ocexp, 1'b1));
    ol = 1'b0;
    wait_clk(4);
    rd(g_field, r);
    check(r, glob(gexp, ocexp, 1'b0));
    $display("test open load done");
    for (int n = 0; n < 6; n++) begin
      v = (n == 0) ? 8'h80 : (n == 1) ? 8'h01 : 8'($random(seed));
      oc = v;
      wait_clk(4);
      oc = 8'h00;
      wait_clk(4);
      ocexp = v;
      rd(o_field, r);
      check(r, ocexp);
      check(soff, ocexp);
      rd(g_field, r);
      check(r, glob(gexp, ocexp, 1'b0));
      clr(o_field);
      ocexp = 8'h00;
      rd(o_field, r);
      check(r, 8'h00);
      rd(g_field, r);
      check(r, glob(gexp, ocexp, 1'b0));
    end
    $display("test overcurrent done");
    oc = 8'h5A;
    wait_clk(4);
    oc = 8'h00;
    wait_clk(4);
    ocexp = 8'h5A;
    host.frame(abyte(1'b1, o_field), 12, r);
    gexp[7] = 1'b1;
    rd(o_field, r);
    check(r, ocexp);
    rd(g_field, r);
    check(r, glob(gexp, ocexp, 1'b0));
    clr(o_field);
    ocexp = 8'h00;
    clr(g_field);
    gexp = 8'h08;
    rd(g_field, r);
    check(r, glob(gexp, ocexp, 1'b0));
    $display("test protocol done");
    ce = 1'b0;
    pulse_flt(3);
    ce = 1'b1;
    wait_clk(4);
    rd(g_field, r);
    check(r, glob(gexp, ocexp, 1'b0));
    $display("test enable done");
    flt[0] = 1'b1;
    oc = 8'h24;
    wait_clk(4);
    gexp[1] = 1'b1;
    ocexp = 8'h24;
    clr(g_field);
    clr(o_field);
    rd(g_field, r);
    check(r, glob(gexp, ocexp, 1'b0));
    rd(o_field, r);
    check(r, ocexp);
    check(soff, ocexp);
    flt[0] = 1'b0;
    oc = 8'h00;
    rd(5'h0A, r);
    check(r, 8'h00);
    clr(5'h0A);
    rd(g_field, r);
    check(r, glob(gexp, ocexp, 1'b0));
    $display("test persist done");
    pulse_flt(0);
    do_reset;
    rd(g_field, r);
    check(r, 8'h00);
    check(soff, 8'h00);
    $display("test reset again done");
    report_and_stop;
  end
endmodule
